// *** hw/packed_decimal_formats.v ***
`timescale 1ns/1ps
`include "decimal_lane_defs.vh"
// Notes on behaviour
// - decimal digit is four bits, zero to nine
// - unpacked byte digit sits in bits 0-3
// - packed byte upper nibble is more significant
// - 80-bit integer, nine bytes, eighteen digits
// - digit 0 at byte 0 low nibble
// - bit 79 is sign, bits 78-72 ignored
// - negatives are sign-magnitude, not two's complement
// - magnitude at most ten^18 minus one
// - load converts exactly to extended precision
// - decimal loads never raise inexact
// - masked invalid store writes indefinite pattern
// - 64-bit operand: byte, word, dword integer lanes
// - 128-bit operand adds quadword lanes
// - 128-bit operand also read as floats
module packed_decimal_formats
(
  input  wire         clk,
  input  wire         arst_n,
  // decimal load: 80-bit memory image to extended precision
  input  wire         load_packed_decimal,
  input  wire [79:0]  load_data,
  output reg          load_done,
  output reg  [79:0]  load_result,
  output reg          load_digit_invalid,
  output reg          load_inexact,
  // decimal store: magnitude and sign to 80-bit memory image
  input  wire         store_packed_decimal_pop,
  input  wire [63:0]  store_magnitude,
  input  wire         store_sign,
  input  wire         store_invalid,
  input  wire         invalid_masked,
  output reg          store_done,
  output reg  [79:0]  store_data,
  output reg          store_write,
  output reg          store_invalid_fault,
  // byte decimal digit path
  input  wire [7:0]   bcd_byte,
  input  wire         bcd_packed,
  input  wire         bcd_muldiv,
  output wire [6:0]   bcd_value,
  output wire         bcd_digit_bad,
  output wire         bcd_high_dirty,
  // vector lane path
  input  wire [127:0] vec_operand,
  input  wire         vec_wide,
  input  wire [1:0]   vec_lane_size,
  input  wire [3:0]   vec_lane_index,
  input  wire [2:0]   vec_fp_kind,
  output wire [63:0]  vec_lane_value,
  output wire         vec_lane_bad,
  output reg  [63:0]  vec_fp_value,
  output reg          vec_fp_bad
);
  // sequencer state codes
  localparam ST_IDLE  = 2'h0; // waiting
  localparam ST_LOAD  = 2'h1; // accumulating digits for load
  localparam ST_STORE = 2'h2; // peeling digits for store
  localparam ST_NORM  = 2'h3; // normalising loaded value

  reg [1:0]  state;     // sequencer state
  reg [4:0]  digit_cnt; // digit counter
  reg [79:0] shadow;    // shifting digit image
  reg [63:0] accum;     // binary magnitude
  reg        sign_hold; // captured sign
  reg        bad_hold;  // bad digit seen
  reg [14:0] exp_hold;  // exponent during normalise
  reg [71:0] digits_out;// digits built for store

  // one nibble is a legal digit
  function nib_ok;
    input [3:0] d;
    begin
      nib_ok = (d <= `DIGIT_MAX);
    end
  endfunction

  // largest storable magnitude, ten^18 - 1
  localparam [63:0] DEC_LIMIT = `DEC_MAG_MAX;

  // magnitude fits in eighteen digits
  function mag_ok;
    input [63:0] m;
    begin
      mag_ok = (m <= DEC_LIMIT);
    end
  endfunction

  // least significant decimal digit of a magnitude
  function [3:0] low_digit10;
    input [63:0] v;
    reg   [63:0] r;
    begin
      r           = v % 64'd10;
      low_digit10 = r[3:0];
    end
  endfunction

  // extended-precision image: sign, biased exponent, significand
  function [79:0] ext_image;
    input        s;
    input [14:0] e;
    input [63:0] m;
    begin
      ext_image = {s, e, m};
    end
  endfunction

  // byte digit helper
  // registered, one clock behind bcd_byte
  bcd_digit_unit u_digit
  (
    .clk                 (clk),
    .arst_n              (arst_n),
    .byte_in             (bcd_byte),
    .packed_mode         (bcd_packed),
    .muldiv_op           (bcd_muldiv),
    .byte_value          (bcd_value),
    .digit_bad           (bcd_digit_bad),
    .high_nibble_nonzero (bcd_high_dirty)
  );

  // integer lane helper
  // registered; a bad lane reads as zero
  vector_lane_unit u_lane
  (
    .clk        (clk),
    .arst_n     (arst_n),
    .operand    (vec_operand),
    .wide       (vec_wide),
    .lane_size  (vec_lane_size),
    .lane_index (vec_lane_index),
    .lane_value (vec_lane_value),
    .lane_bad   (vec_lane_bad)
  );

  // floating interpretation of the 128-bit operand
  // kinds above scalar double flag vec_fp_bad
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vec_fp_value <= 64'h0;
      vec_fp_bad   <= 1'b0;
    end
    else
    begin
      vec_fp_bad <= 1'b0;
      case (vec_fp_kind)
        // packed single: four 32-bit lanes
        `FP_PS: vec_fp_value <= {32'h0, vec_operand[vec_lane_index[1:0]*32 +: 32]};
        // packed double: two 64-bit lanes
        `FP_PD: vec_fp_value <= vec_operand[vec_lane_index[0]*64 +: 64];
        // scalar single: lane zero only
        `FP_SS: vec_fp_value <= {32'h0, vec_operand[31:0]};
        // scalar double: lane zero only
        `FP_SD: vec_fp_value <= vec_operand[63:0];
        default:
        begin
          vec_fp_value <= 64'h0;
          vec_fp_bad   <= (vec_fp_kind != `FP_NONE);
        end
      endcase
    end
  end

  // decimal load and store sequencer, one digit per clock
  // load: eighteen digit steps, then normalising shifts
  // store: eighteen divide-by-ten steps, the write issued on the last step
  // requests while busy are dropped; load wins a tie
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // all state and outputs cleared
      state               <= ST_IDLE;
      digit_cnt           <= 5'h00;
      shadow              <= 80'h0;
      accum               <= 64'h0;
      sign_hold           <= 1'b0;
      bad_hold            <= 1'b0;
      exp_hold            <= 15'h0000;
      digits_out          <= 72'h0;
      load_done           <= 1'b0;
      load_result         <= 80'h0;
      load_digit_invalid  <= 1'b0;
      load_inexact        <= 1'b0;
      store_done          <= 1'b0;
      store_data          <= 80'h0;
      store_write         <= 1'b0;
      store_invalid_fault <= 1'b0;
    end
    else
    begin
      // pulses last one clock
      load_done   <= 1'b0;
      store_done  <= 1'b0;
      store_write <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (load_packed_decimal)
          begin
            // sign from bit 79; bits 78..72 dropped
            sign_hold <= load_data[`DEC_SIGN_BIT];
            shadow    <= {8'h00, load_data[71:0]};
            accum     <= 64'h0;
            bad_hold  <= 1'b0;
            digit_cnt <= 5'h00;
            state     <= ST_LOAD;
          end
          // load wins over store in the same cycle
          else if (store_packed_decimal_pop)
          begin
            // masked invalid: write the indefinite pattern
            if (store_invalid || !mag_ok(store_magnitude))
            begin
              store_invalid_fault <= 1'b1;
              store_done          <= 1'b1;
              if (invalid_masked)
              begin
                store_data  <= `DEC_INDEF;
                store_write <= 1'b1;
              end
            end
            else
            begin
              // valid store: latch operands, start peeling
              store_invalid_fault <= 1'b0;
              sign_hold  <= store_sign;
              accum      <= store_magnitude;
              digits_out <= 72'h0;
              digit_cnt  <= 5'h00;
              state      <= ST_STORE;
            end
          end
        end
        ST_LOAD:
        begin
          // most significant digit first: top nibble of byte 8
          accum <= accum * 64'd10 + {60'h0, shadow[71:68]};
          // a bad digit still accumulates; the flag reports it
          if (!nib_ok(shadow[71:68]))
            bad_hold <= 1'b1;
          shadow    <= {shadow[75:0], 4'h0};
          digit_cnt <= digit_cnt + 5'h01;
          if (digit_cnt == `DEC_DIGITS - 1)
          begin
            exp_hold <= `EXT_BIAS + 15'd63;
            state    <= ST_NORM;
          end
        end
        ST_NORM:
        begin
          // shift until integer bit set; exact since 18 digits fit 64 bits
          if (accum == 64'h0)
          begin
            // zero keeps its sign, exponent field zero
            load_result        <= ext_image(sign_hold, 15'h0000, 64'h0);
            load_done          <= 1'b1;
            load_digit_invalid <= bad_hold;
            load_inexact       <= 1'b0;
            state              <= ST_IDLE;
          end
          else if (accum[63])
          begin
            // sign-magnitude: sign only flips bit 79
            load_result        <= ext_image(sign_hold, exp_hold, accum);
            load_done          <= 1'b1;
            load_digit_invalid <= bad_hold;
            load_inexact       <= 1'b0;
            state              <= ST_IDLE;
          end
          else
          begin
            // one left shift per clock, exponent follows
            accum    <= {accum[62:0], 1'b0};
            exp_hold <= exp_hold - 15'h0001;
          end
        end
        ST_STORE:
        begin
          // least significant digit enters at the top, drifts down to byte 0
          digits_out <= {low_digit10(accum), digits_out[71:4]};
          accum      <= accum / 64'd10;
          digit_cnt  <= digit_cnt + 5'h01;
          // last step: digit 0 lands in bits 3..0
          if (digit_cnt == `DEC_DIGITS - 1)
          begin
            // sign-magnitude: only bit 79 marks a negative value
            store_data  <= {sign_hold, 7'h00, low_digit10(accum), digits_out[71:4]};
            store_write <= 1'b1;
            store_done  <= 1'b1;
            state       <= ST_IDLE;
          end
        end
        // unused code: back to idle
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // packed_decimal_formats

// *** hw/decimal_lane_defs.vh ***
`ifndef DECIMAL_LANE_DEFS_VH
`define DECIMAL_LANE_DEFS_VH
// digit and byte geometry
`define DIGIT_W         4
`define DIGIT_MAX       4'h9
`define DEC_W           80
`define DEC_DIGITS      18
`define DEC_DIGIT_BYTES 9
`define DEC_SIGN_BIT    79
`define DEC_MAG_MAX     64'h0DE0B6B3A763FFFF
// sign of the masked invalid store pattern and its magnitude field
`define DEC_INDEF       80'hFFFFC000000000000000
// extended-precision layout
`define EXT_BIAS        15'h3FFF
`define EXT_SIG_W       64
// lane size codes
`define LANE_BYTE       2'h0
`define LANE_WORD       2'h1
`define LANE_DWORD      2'h2
`define LANE_QWORD      2'h3
// floating interpretation codes
`define FP_NONE         3'h0
`define FP_PS           3'h1
`define FP_PD           3'h2
`define FP_SS           3'h3
`define FP_SD           3'h4
`endif

// *** hw/bcd_digit_unit.v ***
`timescale 1ns/1ps
`include "decimal_lane_defs.vh"
// per-byte decimal digit extraction for unpacked and packed bytes
module bcd_digit_unit
(
  input  wire       clk,
  input  wire       arst_n,
  input  wire [7:0] byte_in,
  input  wire       packed_mode,
  input  wire       muldiv_op,
  output reg  [6:0] byte_value,
  output reg        digit_bad,
  output reg        high_nibble_nonzero
);
  wire [3:0] low_digit  = byte_in[3:0]; // digit in bits 0..3
  wire [3:0] high_digit = byte_in[7:4]; // upper nibble
  // digit valid only 0..9
  function digit_ok;
    input [3:0] d;
    begin
      digit_ok = (d <= `DIGIT_MAX);
    end
  endfunction
  // registered decode
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      byte_value          <= 7'h00;
      digit_bad           <= 1'b0;
      high_nibble_nonzero <= 1'b0;
    end
    else if (packed_mode)
    begin
      // upper digit weighs ten
      byte_value <= {3'h0, high_digit} * 7'h0A + {3'h0, low_digit};
      digit_bad  <= !digit_ok(low_digit) || !digit_ok(high_digit);
      high_nibble_nonzero <= 1'b0;
    end
    else
    begin
      // unpacked: value is low nibble only
      byte_value <= {3'h0, low_digit};
      digit_bad  <= !digit_ok(low_digit);
      // flag a dirty upper nibble for multiply or divide
      high_nibble_nonzero <= muldiv_op && (high_digit != 4'h0);
    end
  end
endmodule // bcd_digit_unit

// *** hw/vector_lane_unit.v ***
`timescale 1ns/1ps
`include "decimal_lane_defs.vh"
// selects one lane from a 64- or 128-bit packed operand
module vector_lane_unit
(
  input  wire         clk,
  input  wire         arst_n,
  input  wire [127:0] operand,
  input  wire         wide,
  input  wire [1:0]   lane_size,
  input  wire [3:0]   lane_index,
  output reg  [63:0]  lane_value,
  output reg          lane_bad
);
  // lanes in an operand for a given size
  function [4:0] lane_count;
    input       w;
    input [1:0] sz;
    begin
      lane_count = (w ? 5'h10 : 5'h08) >> sz;
    end
  endfunction
  reg [63:0] pick; // selected lane, zero extended
  reg        bad;  // index or size out of range
  // lane 0 in the low bits, ascending upward
  always @*
  begin
    pick = 64'h0;
    bad  = ({1'b0, lane_index} >= lane_count(wide, lane_size));
    // quadword lanes only on 128-bit operands
    if (!wide && lane_size == `LANE_QWORD)
      bad = 1'b1;
    case (lane_size)
      `LANE_BYTE:  pick = {56'h0, operand[lane_index*8 +: 8]};
      `LANE_WORD:  pick = {48'h0, operand[lane_index[2:0]*16 +: 16]};
      `LANE_DWORD: pick = {32'h0, operand[lane_index[1:0]*32 +: 32]};
      `LANE_QWORD: pick = operand[lane_index[0]*64 +: 64];
      default:     pick = 64'h0;
    endcase
    if (bad)
      pick = 64'h0;
  end
  // register the lane
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lane_value <= 64'h0;
      lane_bad   <= 1'b0;
    end
    else
    begin
      lane_value <= pick;
      lane_bad   <= bad;
    end
  end
endmodule // vector_lane_unit

// *** bench/exec_side_model.sv ***
`timescale 1ns/1ps
`include "decimal_lane_defs.vh"
// issuing side: one decimal load or store at a time, driven on falling edges
module exec_side_model
(
  input  wire        clk,
  input  wire        load_done,
  input  wire        store_done,
  output reg         load_packed_decimal,
  output reg         store_packed_decimal_pop,
  output reg  [79:0] load_data
);
  // idle until the first request
  initial
  begin
    load_packed_decimal = 1'b0;
    store_packed_decimal_pop = 1'b0;
    load_data = 80'h0;
  end
  // one-cycle request after a gap, then a bounded wait for completion
  task automatic issue(input bit st, input [79:0] img, input int gap);
    if (!st && img === `DEC_INDEF)
      return;
    repeat (gap) @(negedge clk);
    load_data = img;
    load_packed_decimal = !st;
    store_packed_decimal_pop = st;
    @(negedge clk);
    load_packed_decimal = 1'b0;
    store_packed_decimal_pop = 1'b0;
    load_data = ~img; // image no longer held
    for (int n = 0; n < 100 && !(load_done || store_done); n++)
      @(negedge clk);
  endtask
endmodule // exec_side_model

// *** bench/pdf_checker.sv ***
`timescale 1ns/1ps
`include "decimal_lane_defs.vh"
// port-level watch of the decimal and lane paths
module pdf_checker
(
  input wire        clk,
  input wire        arst_n,
  input wire        load_packed_decimal,
  input wire        load_done,
  input wire        load_inexact,
  input wire        store_packed_decimal_pop,
  input wire [63:0] store_magnitude,
  input wire        store_sign,
  input wire        store_invalid,
  input wire        invalid_masked,
  input wire        store_done,
  input wire        store_write,
  input wire [79:0] store_data,
  input wire        store_invalid_fault,
  input wire [7:0]  bcd_byte,
  input wire        bcd_packed,
  input wire        bcd_muldiv,
  input wire        bcd_digit_bad,
  input wire        bcd_high_dirty,
  input wire        vec_wide,
  input wire [1:0]  vec_lane_size,
  input wire [3:0]  vec_lane_index,
  input wire        vec_lane_bad
);
  reg  busy;                                                       // operation in flight
  wire ld_go = !busy && load_packed_decimal;                       // load taken
  wire st_go = !busy && !load_packed_decimal && store_packed_decimal_pop; // store taken
  wire st_bad = store_invalid || store_magnitude > 64'h0DE0B6B3A763FFFF;  // faulting store
  wire dirty_in = !bcd_packed && bcd_muldiv && |bcd_byte[7:4];     // upper nibble left set
  wire nib_bad = bcd_byte[3:0] > 4'h9 || bcd_packed && bcd_byte[7:4] > 4'h9; // digit over nine
  wire lane_oob = {1'b0, vec_lane_index} >= (5'h08 << vec_wide) >> vec_lane_size
    || !vec_wide && vec_lane_size == 2'h3;                         // lane outside operand
  // tracks the outstanding operation
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      busy <= 1'b0;
    else if (load_done || store_done)
      busy <= 1'b0;
    else if (ld_go || st_go)
      busy <= 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_no_inexact: assert property (!load_inexact)
    else $error("inexact on load");
  chk_load_time: assert property (ld_go |-> ##[20:83] load_done)
    else $error("load not done in time");
  chk_fault_next: assert property (st_go && st_bad |=> store_done && store_invalid_fault)
    else $error("no fault after bad store");
  chk_indef_write: assert property (st_go && store_invalid && invalid_masked
    |=> store_write && store_data == `DEC_INDEF) else $error("indefinite not written");
  chk_store_image: assert property (st_go && !st_bad |-> ##19 store_write
    && store_data[79:72] == {$past(store_sign, 19), 7'h00}
    && store_data[3:0] == 4'($past(store_magnitude, 19) % 10)) else $error("bad image");
  chk_unmasked_quiet: assert property (st_go && st_bad && !invalid_masked |=> !store_write)
    else $error("write on unmasked invalid");
  chk_dirty_flag: assert property (1'b1 |=> bcd_high_dirty == $past(dirty_in))
    else $error("dirty flag wrong");
  chk_digit_bad: assert property (1'b1 |=> bcd_digit_bad == $past(nib_bad))
    else $error("digit flag wrong");
  chk_lane_bad: assert property (1'b1 |=> vec_lane_bad == $past(lane_oob))
    else $error("lane flag wrong");
  cov_load: cover property (load_done);
  cov_indef: cover property (store_write && store_data == `DEC_INDEF);
  cov_dirty: cover property (bcd_high_dirty);
  cov_neg_store: cover property (store_write && store_data[79] && store_data != `DEC_INDEF);
endmodule // pdf_checker
bind packed_decimal_formats pdf_checker pdf_checker_i
(
  .clk                      (clk),
  .arst_n                   (arst_n),
  .load_packed_decimal      (load_packed_decimal),
  .load_done                (load_done),
  .load_inexact             (load_inexact),
  .store_packed_decimal_pop (store_packed_decimal_pop),
  .store_magnitude          (store_magnitude),
  .store_sign               (store_sign),
  .store_invalid            (store_invalid),
  .invalid_masked           (invalid_masked),
  .store_done               (store_done),
  .store_write              (store_write),
  .store_data               (store_data),
  .store_invalid_fault      (store_invalid_fault),
  .bcd_byte                 (bcd_byte),
  .bcd_packed               (bcd_packed),
  .bcd_muldiv               (bcd_muldiv),
  .bcd_digit_bad            (bcd_digit_bad),
  .bcd_high_dirty           (bcd_high_dirty),
  .vec_wide                 (vec_wide),
  .vec_lane_size            (vec_lane_size),
  .vec_lane_index           (vec_lane_index),
  .vec_lane_bad             (vec_lane_bad)
);

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`include "decimal_lane_defs.vh"
// random and corner traffic through all four paths
module tb_top;
  logic         clk = 1'b0;     // core clock
  logic         arst_n = 1'b0;  // held low at start
  logic         load_packed_decimal, store_packed_decimal_pop, load_done, store_done;
  logic         load_digit_invalid, load_inexact, store_write, store_invalid_fault;
  logic         store_sign, store_invalid, invalid_masked, bcd_packed, bcd_muldiv;
  logic         bcd_digit_bad, bcd_high_dirty, vec_wide, vec_lane_bad, vec_fp_bad;
  logic [79:0]  load_data, load_result, store_data;
  logic [63:0]  store_magnitude, vec_lane_value, vec_fp_value;
  logic [127:0] vec_operand;
  logic [7:0]   bcd_byte, e;    // e: expected flag and digit value
  logic [6:0]   bcd_value;
  logic [3:0]   vec_lane_index;
  logic [2:0]   vec_fp_kind;
  logic [1:0]   vec_lane_size;
  int           n_fail = 0, samples_checked = 0, seed = 48084;
  logic [79:0]  lc [4] = '{80'h0, 80'h80000000000000000001,
                           80'h7F999999999999999999, 80'h80999999999999999999};
  packed_decimal_formats packed_decimal_formats_i
  (
    .clk                      (clk),
    .arst_n                   (arst_n),
    .load_packed_decimal      (load_packed_decimal),
    .load_data                (load_data),
    .load_done                (load_done),
    .load_result              (load_result),
    .load_digit_invalid       (load_digit_invalid),
    .load_inexact             (load_inexact),
    .store_packed_decimal_pop (store_packed_decimal_pop),
    .store_magnitude          (store_magnitude),
    .store_sign               (store_sign),
    .store_invalid            (store_invalid),
    .invalid_masked           (invalid_masked),
    .store_done               (store_done),
    .store_data               (store_data),
    .store_write              (store_write),
    .store_invalid_fault      (store_invalid_fault),
    .bcd_byte                 (bcd_byte),
    .bcd_packed               (bcd_packed),
    .bcd_muldiv               (bcd_muldiv),
    .bcd_value                (bcd_value),
    .bcd_digit_bad            (bcd_digit_bad),
    .bcd_high_dirty           (bcd_high_dirty),
    .vec_operand              (vec_operand),
    .vec_wide                 (vec_wide),
    .vec_lane_size            (vec_lane_size),
    .vec_lane_index           (vec_lane_index),
    .vec_fp_kind              (vec_fp_kind),
    .vec_lane_value           (vec_lane_value),
    .vec_lane_bad             (vec_lane_bad),
    .vec_fp_value             (vec_fp_value),
    .vec_fp_bad               (vec_fp_bad)
  );
  exec_side_model exec_side_model_i
  (
    .clk                      (clk),
    .load_done                (load_done),
    .store_done               (store_done),
    .load_packed_decimal      (load_packed_decimal),
    .store_packed_decimal_pop (store_packed_decimal_pop),
    .load_data                (load_data)
  );
  always #50 clk = ~clk;
  // extended image of a decimal memory image
  function automatic [79:0] to_ext(input [79:0] img);
    logic [63:0] m;
    int p;
    m = 64'h0;
    p = 63;
    for (int i = 17; i >= 0; i--)
      m = m * 10 + img[i*4 +: 4];
    if (m == 0)
      return {img[79], 79'h0};
    for (; !m[63]; p--)
      m = m << 1;
    return {img[79], `EXT_BIAS + 15'(p), m};
  endfunction
  // sign-magnitude decimal image of a binary magnitude
  function automatic [79:0] to_dec(input s, input [63:0] m);
    to_dec = {s, 79'h0};
    for (int i = 0; i < 18; i++)
    begin
      to_dec[i*4 +: 4] = 4'(m % 10);
      m = m / 10;
    end
  endfunction
  // random digits under random sign and junk bits
  function automatic [79:0] rnd_img();
    rnd_img = {$random(seed), $random(seed), 16'h0};
    for (int i = 0; i < 18; i++)
      rnd_img[i*4 +: 4] = 4'($unsigned($random(seed)) % 10);
  endfunction
  // expected lane: bad flag over zero-extended value
  function automatic [64:0] lane_exp(input [127:0] op, input w, input [1:0] sz,
                                     input [3:0] ix);
    if ({1'b0, ix} >= (5'h08 << w) >> sz || (!w && sz == 2'h3))
      return {1'b1, 64'h0};
    return {1'b0, 64'((op >> (ix * (8 << sz))) & ((128'h1 << (8 << sz)) - 1))};
  endfunction
  // expected floating view: bad flag over the selected bits
  function automatic [64:0] fp_exp(input [127:0] op, input [2:0] kd, input [3:0] ix);
    case (kd)
      `FP_PS:  return {33'h0, 32'(op >> (32 * ix[1:0]))};
      `FP_PD:  return {1'b0, 64'(op >> (64 * ix[0]))};
      `FP_SS:  return {33'h0, op[31:0]};
      `FP_SD:  return {1'b0, op[63:0]};
      default: return {kd != `FP_NONE, 64'h0};
    endcase
  endfunction
  // one comparison, reported on mismatch
  task automatic check(input [79:0] got, input [79:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one load through the partner
  task automatic do_load(input [79:0] img);
    exec_side_model_i.issue(1'b0, img, $unsigned($random(seed)) % 3 + 1);
    check(load_result, to_ext(img));
    check(load_inexact, 1'b0);
    check(load_digit_invalid, 1'b0);
  endtask
  // one store with the given exception state
  task automatic do_store(input s, input inv, input msk, input [63:0] m);
    store_sign = s;
    store_invalid = inv;
    invalid_masked = msk;
    store_magnitude = m;
    exec_side_model_i.issue(1'b1, 80'h0, 1);
    store_magnitude = ~m;
    if (inv && msk)
      check(store_data, `DEC_INDEF);
    else if (inv || m > 64'h0DE0B6B3A763FFFF)
      check(store_invalid_fault, 1'b1);
    else
      check(store_data, to_dec(s, m));
  endtask
  // verdict and end of run
  task automatic final_report;
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {store_sign, store_invalid, invalid_masked, bcd_packed, bcd_muldiv, vec_wide} = '0;
    {store_magnitude, vec_operand, bcd_byte, vec_lane_index, vec_fp_kind} = '0;
    vec_lane_size = 2'h0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    for (int k = 0; k < 12; k++)
      do_load(k < 4 ? lc[k] : rnd_img());
    exec_side_model_i.issue(1'b0, `DEC_INDEF, 1);
    exec_side_model_i.issue(1'b0, 80'hA0, 1);
    check(load_digit_invalid, 1'b1);
    do_store(1'b1, 1'b0, 1'b0, 64'h0DE0B6B3A763FFFF);
    do_store(1'b0, 1'b0, 1'b0, 64'h0DE0B6B3A7640000);
    do_store(1'b1, 1'b1, 1'b1, 64'h5);
    do_store(1'b0, 1'b1, 1'b0, 64'h5);
    for (int k = 0; k < 8; k++)
      do_store(k[0], 1'b0, 1'b0, {$random(seed), $random(seed)} % 64'h0DE0B6B3A7640000);
    for (int k = 0; k < 96; k++)
    begin
      bcd_byte = 8'($random(seed));
      {bcd_muldiv, bcd_packed} = 2'(k);
      vec_operand = {$random(seed), $random(seed), $random(seed), $random(seed)};
      {vec_lane_size, vec_wide} = 3'(k >> 2);
      vec_lane_index = 4'($random(seed));
      vec_fp_kind = 3'($random(seed));
      e = bcd_packed ? {bcd_byte[7:4] > 4'h9 || bcd_byte[3:0] > 4'h9,
                        7'(bcd_byte[7:4] * 10 + bcd_byte[3:0])}
                     : {bcd_byte[3:0] > 4'h9, 3'h0, bcd_byte[3:0]};
      @(negedge clk);
      check(bcd_digit_bad, e[7]);
      if (!e[7] && !(bcd_muldiv && !bcd_packed && |bcd_byte[7:4]))
        check(bcd_value, e[6:0]);
      check({vec_lane_bad, vec_lane_value},
            lane_exp(vec_operand, vec_wide, vec_lane_size, vec_lane_index));
      check({vec_fp_bad, vec_fp_value}, fp_exp(vec_operand, vec_fp_kind, vec_lane_index));
      check(bcd_high_dirty, bcd_muldiv && !bcd_packed && |bcd_byte[7:4]);
    end
    final_report;
  end
  // cuts a hang short
  initial
  begin
    #500000;
    n_fail++;
    final_report;
  end
endmodule // tb_top
